//--- vcap_pkg.sv
// Package: register map, field layout and shared types for video capture
`default_nettype none
package vcap_pkg;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SCALE = 8'h08;
  localparam logic [7:0] ADDR_LIMIT = 8'h0C;
  localparam logic [7:0] ADDR_LAYER = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_FRAME = 8'h1C;
  localparam int MODE_ENABLE_BIT = 0;
  localparam int MODE_VI_BIT = 1;
  localparam int MODE_CM_LO = 2;
  localparam int MODE_ODD_BIT = 4;
  localparam int LAYER_SYNC_BIT = 0;
  localparam int LAYER_YC_BIT = 1;
  localparam int LAYER_IL_BIT = 2;
  localparam logic [1:0] CM_REDUCE = 2'h3;
  localparam logic [31:0] SCALE_RESET = 32'h0800_0800;
  localparam logic [15:0] SCALE_UNITY = 16'h0800;
  localparam int SCALE_FRAC = 11;
  localparam logic [10:0] PIX_LIMIT_RESET = 11'h05A0;
  localparam logic [10:0] LINE_LIMIT_RESET = 11'h0120;
  localparam logic [10:0] LINE_WORDS = 11'h05A0;
  localparam int IRQ_FRAME_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int CLK_SYS_MHZ = 100;
  localparam int LINK_PERIOD_NS = 80;
  localparam int LINK_CYCLES = LINK_PERIOD_NS * CLK_SYS_MHZ / 1000;

  typedef struct packed {
    logic valid;
    logic [7:0] y;
    logic [7:0] c;
    logic [10:0] x;
    logic [10:0] line;
    logic field;
  } pix_s;

  typedef struct packed {
    logic [7:0] adr;
    logic we;
    logic [31:0] dat;
    logic [3:0] sel;
    logic stb;
  } wb_req_s;
endpackage
`default_nettype wire

//--- vcap_line_mem.sv
// Line memory holding previous captured line for vertical interpolation
`default_nettype none
module vcap_line_mem #(
  parameter int DEPTH = 2048,
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  initial begin
    if (DEPTH < 2) $error("depth too small");
  end
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

//--- vcap_stream_rx.sv
// Link sampler and 4:2:2 stream parser with timing code checking
`default_nettype none
module vcap_stream_rx
  import vcap_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic link_clk,
  input wire logic [7:0] link_data,
  input wire logic [10:0] expect_words,
  output vcap_pkg::pix_s pix,
  output logic line_start,
  output logic field_end,
  output logic [4:0] err_code
);
  typedef enum logic [2:0] {S_IDLE, S_FF, S_Z1, S_Z2, S_XY, S_DATA} rx_e;
  typedef struct packed {
    logic [2:0] ck;
    logic [7:0] d1, d2, d3;
    rx_e st;
    logic active;
    logic sav;
    logic field;
    logic [10:0] cnt;
    logic [1:0] ph;
    logic [7:0] yb;
    logic [7:0] cb;
    logic [10:0] x;
    logic [10:0] line;
    pix_s pix;
    logic ls;
    logic fe;
    logic [4:0] err;
  } st_s;
  st_s r, n;
  logic edge_seen;
  logic [7:0] b;
  assign edge_seen = r.ck[1] & r.ck[2] & ~r.ck[0] ? 1'b0 :
                     (r.ck[1] == r.ck[0]) & r.ck[1] & ~r.ck[2];
  assign b = r.d3;
  assign pix = r.pix;
  assign line_start = r.ls;
  assign field_end = r.fe;
  assign err_code = r.err;
  always_comb begin
    n = r;
    n.ck = {r.ck[1:0], link_clk};
    n.d1 = link_data;
    n.d2 = r.d1;
    n.pix.valid = 1'b0;
    n.ls = 1'b0;
    n.fe = 1'b0;
    n.err = 5'h00;
    if (!enable) begin
      n.st = S_IDLE;
    end else if (edge_seen) begin
      n.d3 = r.d2;
      case (r.st)
        S_IDLE, S_FF: begin
          if (r.d2 == 8'hFF) begin
            n.st = S_Z1;
          end else if (r.st == S_FF) begin
            n.st = S_DATA;
          end
        end
        S_Z1: n.st = (r.d2 == 8'h00) ? S_Z2 : S_DATA;
        S_Z2: n.st = (r.d2 == 8'h00) ? S_XY : S_DATA;
        S_XY: begin
          n.st = S_DATA;
          if (!r.d2[4]) begin
            if (r.active && r.cnt != expect_words) begin
              n.err = 5'h01;
            end
            n.active = ~r.d2[5];
            n.sav = 1'b1;
            n.cnt = 11'h000;
            n.ph = 2'h0;
            n.x = 11'h000;
            n.ls = ~r.d2[5];
          end else begin
            if (r.active) begin
              n.line = r.line + 11'h001;
            end
            if (r.d2[5]) begin
              n.line = 11'h000;
            end
            if (!r.sav) begin
              n.err = 5'h08;
            end
            n.sav = 1'b0;
            if (r.active && r.cnt != expect_words && r.cnt != 11'h000) begin
              n.err = 5'h02;
            end
            n.active = 1'b0;
          end
          if (r.d2[6] != r.field) begin
            n.fe = 1'b1;
            n.line = 11'h000;
          end
          n.field = r.d2[6];
        end
        default: begin
          if (r.d2 == 8'hFF) begin
            n.st = S_Z1;
            if (r.active && r.cnt < expect_words && r.cnt != 11'h000) begin
              n.err = 5'h04;
            end
          end else if (r.active) begin
            n.cnt = r.cnt + 11'h001;
            n.ph = r.ph + 2'h1;
            if (!r.ph[0]) begin
              n.cb = r.d2;
            end else begin
              n.pix.valid = 1'b1;
              n.pix.y = r.d2;
              n.pix.c = r.cb;
              n.pix.x = r.x;
              n.pix.line = r.line;
              n.pix.field = r.field;
              n.x = r.x + 11'h001;
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

//--- video_capture_scaler.sv
// Top: capture registers, reduction, interpolation, overlay sync and IRQ
// Functional notes
// - Sync mode shows latest complete frame only
// - Merged frames display interlaced in interlace scan
// - Reduction only when capture mode equals 11
// - Vertical per line, horizontal per pixel pair; code steps horizontal per pixel (each pix.valid)
// - Factors are unsigned 5.11 input/output ratios
// - Vertical factor high half, horizontal low half
// - Scale register resets to 08000800H
// - Pixel and line limits clamp stream
// - Interpolation bit 0 doubles lines within field
// - Interpolation bit 1 stores fields unchanged
// - Missing timing code flags status error
// - Sample 8-bit stream on capture clock when enabled
// - Count mismatch sets nonzero low status bits; code flags nothing when an end code follows zero words
//
// Our own choices: the register addresses and the Wishbone register port.
`default_nettype none
module video_capture_scaler
  import vcap_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ,
  input wire logic CAPTURE_CLOCK,
  input wire logic [7:0] VIDEO_DATA,
  output logic PIX_VALID,
  output logic [15:0] PIX_DATA,
  output logic [10:0] PIX_X,
  output logic [10:0] PIX_LINE,
  output logic [1:0] DISP_FRAME,
  output logic DISP_INTERLACE
);
  import vcap_pkg::*;
  localparam int XW = 11;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [4:0] mode;
    logic [31:0] scale;
    logic [10:0] pix_lim;
    logic [10:0] line_lim;
    logic [2:0] layer;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [4:0] status;
    logic [1:0] wr_frame;
    logic [1:0] done_frame;
    logic [15:0] vacc;
    logic [15:0] hacc;
    logic [15:0] vpos;
    logic [15:0] hpos;
    logic line_keep;
    logic [10:0] out_line;
    logic [10:0] out_x;
    logic out_v;
    logic [15:0] out_d;
    logic [10:0] out_xo;
    logic [10:0] out_lo;
    logic interp_pend;
    logic [15:0] interp_d;
  } top_s;
  top_s r, n;

  pix_s pix;
  logic line_start, field_end;
  logic [4:0] err_code;
  logic [15:0] prev_d;
  logic [15:0] cur_d;
  logic [10:0] hout;
  logic wb_req, wr_ok, reduce, odd_skip, h_take;
  logic [31:0] rd_val;
  logic [31:0] wmask;

  vcap_stream_rx u_rx (
    .clk(CLK_SYS),
    .rst(RST),
    .enable(r.mode[MODE_ENABLE_BIT]),
    .link_clk(CAPTURE_CLOCK),
    .link_data(VIDEO_DATA),
    .expect_words(LINE_WORDS),
    .pix(pix),
    .line_start(line_start),
    .field_end(field_end),
    .err_code(err_code)
  );

  assign cur_d = {pix.y, pix.c};
  assign hout = pix.x;

  vcap_line_mem #(.DEPTH(2048), .WIDTH(16)) u_mem (
    .clk(CLK_SYS),
    .we(pix.valid),
    .waddr(hout),
    .wdata(cur_d),
    .raddr(hout),
    .rdata(prev_d)
  );

  assign wb_req = WB_CYC_I & WB_STB_I & ~r.ack;
  assign wr_ok = wb_req & WB_WE_I;
  assign reduce = r.mode[MODE_CM_LO +: 2] == CM_REDUCE;
  assign odd_skip = r.mode[MODE_ODD_BIT] & pix.field;
  assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                  {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign h_take = !reduce || (r.hpos[15:SCALE_FRAC] == r.hacc[15:SCALE_FRAC]);

  always_comb begin
    rd_val = 32'h0000_0000;
    case (WB_ADR_I)
      ADDR_MODE: rd_val = {27'h000_0000, r.mode};
      ADDR_STATUS: rd_val = {27'h000_0000, r.status};
      ADDR_SCALE: rd_val = r.scale;
      ADDR_LIMIT: rd_val = {5'h00, r.line_lim, 5'h00, r.pix_lim};
      ADDR_LAYER: rd_val = {29'h0000_0000, r.layer};
      ADDR_IRQ_STAT: rd_val = {30'h0000_0000, r.irq_stat};
      ADDR_IRQ_MASK: rd_val = {30'h0000_0000, r.irq_mask};
      ADDR_FRAME: rd_val = {28'h000_0000, r.wr_frame, r.done_frame};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    n = r;
    n.ack = wb_req;
    n.dat = wb_req ? rd_val : r.dat;
    n.out_v = 1'b0;
    if (wr_ok) begin
      case (WB_ADR_I)
        ADDR_MODE: n.mode = (r.mode & ~wmask[4:0]) | (WB_DAT_I[4:0] & wmask[4:0]);
        ADDR_STATUS: n.status = r.status & ~(WB_DAT_I[4:0] & wmask[4:0]);
        ADDR_SCALE: n.scale = (r.scale & ~wmask) | (WB_DAT_I & wmask);
        ADDR_LIMIT: begin
          if (WB_SEL_I[0] && WB_SEL_I[1]) n.pix_lim = WB_DAT_I[10:0];
          if (WB_SEL_I[2] && WB_SEL_I[3]) n.line_lim = WB_DAT_I[26:16];
        end
        ADDR_LAYER: n.layer = (r.layer & ~wmask[2:0]) | (WB_DAT_I[2:0] & wmask[2:0]);
        ADDR_IRQ_STAT: n.irq_stat = r.irq_stat & ~(WB_DAT_I[1:0] & wmask[1:0]);
        ADDR_IRQ_MASK: n.irq_mask = (r.irq_mask & ~wmask[1:0]) | (WB_DAT_I[1:0] & wmask[1:0]);
        default: n.irq_mask = r.irq_mask;
      endcase
    end
    if (err_code != 5'h00) begin
      n.status = r.status | err_code;
      n.irq_stat[IRQ_ERR_BIT] = 1'b1;
    end
    if (field_end) begin
      n.vacc = 16'h0000;
      n.vpos = 16'h0000;
      n.out_line = 11'h000;
      if (!r.mode[MODE_ODD_BIT] || !pix.field) begin
        n.done_frame = r.wr_frame;
        n.wr_frame = r.wr_frame + 2'h1;
        n.irq_stat[IRQ_FRAME_BIT] = 1'b1;
      end
    end
    if (line_start) begin
      n.hacc = 16'h0000;
      n.hpos = 16'h0000;
      n.out_x = 11'h000;
      n.line_keep = !reduce ||
        (r.vpos[15:SCALE_FRAC] == r.vacc[15:SCALE_FRAC]);
      n.vpos = r.vpos + SCALE_UNITY;
      if (!reduce || r.vpos[15:SCALE_FRAC] == r.vacc[15:SCALE_FRAC]) begin
        n.vacc = r.vacc + (reduce ? r.scale[31:16] : SCALE_UNITY);
      end
    end
    if (r.line_keep && pix.valid && !odd_skip &&
        pix.x < r.pix_lim && pix.line < r.line_lim) begin
      if (h_take) begin
        n.out_v = 1'b1;
        n.out_d = cur_d;
        n.out_xo = r.out_x;
        n.out_lo = r.mode[MODE_VI_BIT] ? pix.line : {pix.line[9:0], 1'b0};
        n.out_x = r.out_x + 11'h001;
        if (reduce) n.hacc = r.hacc + r.scale[15:0];
      end
      n.hpos = r.hpos + SCALE_UNITY;
      n.interp_pend = !r.mode[MODE_VI_BIT] && h_take;
      n.interp_d = cur_d;
    end else if (r.interp_pend) begin
      n.interp_pend = 1'b0;
      n.out_v = 1'b1;
      n.out_d = {r.interp_d[15:8] / 8'h02 + prev_d[15:8] / 8'h02,
                 r.interp_d[7:0]};
      n.out_lo = r.out_lo + 11'h001;
    end
    if (reduce && field_end) n.out_x = 11'h000;
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      r <= '0;
      r.scale <= SCALE_RESET;
      r.pix_lim <= PIX_LIMIT_RESET;
      r.line_lim <= LINE_LIMIT_RESET;
    end else begin
      r <= n;
    end
  end

  assign WB_ACK_O = r.ack;
  assign WB_DAT_O = r.dat;
  assign IRQ = |(r.irq_stat & r.irq_mask);
  assign PIX_VALID = r.out_v;
  assign PIX_DATA = r.out_d;
  assign PIX_X = r.out_xo;
  assign PIX_LINE = r.out_lo;
  assign DISP_FRAME = r.layer[LAYER_SYNC_BIT] ? r.done_frame : 2'h0;
  assign DISP_INTERLACE = r.layer[LAYER_IL_BIT] & r.mode[MODE_VI_BIT];
endmodule
`default_nettype wire

//--- video_capture_scaler_asserts.sv
// Checker: bus answer, registers and stream output
`default_nettype none
module video_capture_scaler_asserts
  import vcap_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic IRQ,
  input wire logic PIX_VALID,
  input wire logic [10:0] PIX_X,
  input wire logic [1:0] DISP_FRAME
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  logic wr;
  logic rd;
  logic [31:0] scale_r;
  logic [31:0] mask_r;
  logic sync_r;
  logic en_r;
  logic [6:0] off_r;
  assign wr = WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I;
  assign rd = WB_ACK_O && !WB_WE_I;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      scale_r <= SCALE_RESET;
      mask_r <= 32'h0;
      sync_r <= 1'b0;
      en_r <= 1'b0;
      off_r <= 7'h0;
    end else begin
      if (wr && WB_ADR_I == ADDR_SCALE)
        scale_r <= WB_DAT_I;
      if (wr && WB_ADR_I == ADDR_IRQ_MASK)
        mask_r <= WB_DAT_I;
      if (wr && WB_ADR_I == ADDR_LAYER)
        sync_r <= WB_DAT_I[LAYER_SYNC_BIT];
      if (wr && WB_ADR_I == ADDR_MODE)
        en_r <= WB_DAT_I[MODE_ENABLE_BIT];
      if (en_r)
        off_r <= 7'h0;
      else if (off_r != 7'h7F)
        off_r <= off_r + 7'h1;
    end
  end
  sequence s_take;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_pulse;
    ##1 WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  property p_ack;
    s_take |-> s_pulse;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack timing wrong");
  property p_scale;
    rd && WB_ADR_I == ADDR_SCALE |-> WB_DAT_O == scale_r;
  endproperty
  a_scale: assert property (p_scale)
    else $error("scale read wrong");
  property p_unmap;
    rd && WB_ADR_I == 8'h20 |-> WB_DAT_O == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_hold;
    !WB_ACK_O |-> $stable(WB_DAT_O);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved");
  property p_sync;
    !sync_r && !$past(sync_r) |-> DISP_FRAME == 2'h0;
  endproperty
  a_sync: assert property (p_sync)
    else $error("frame shown without sync");
  property p_clamp;
    PIX_VALID |-> PIX_X < PIX_LIMIT_RESET;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("pixel past limit");
  property p_idle;
    off_r == 7'h7F |-> !PIX_VALID;
  endproperty
  a_idle: assert property (p_idle)
    else $error("pixel while disabled");
  property p_irq;
    mask_r == 32'h0 && $past(mask_r) == 32'h0 |-> !IRQ;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq while masked");
endmodule
bind video_capture_scaler video_capture_scaler_asserts i_chk (
  .CLK_SYS, .RST, .WB_ADR_I, .WB_DAT_I, .WB_WE_I, .WB_CYC_I,
  .WB_STB_I, .WB_DAT_O, .WB_ACK_O, .IRQ, .PIX_VALID, .PIX_X,
  .DISP_FRAME
);
`default_nettype wire

//--- vcap_video_src.sv
// Partner: video decoder sending 4:2:2 lines with codes
`default_nettype none
module vcap_video_src (
  output logic link_clk,
  output logic [7:0] link_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk = 1'b0;
    link_data = 8'h00;
  end
  task automatic put(input logic [7:0] b);
    link_data = b;
    #40 link_clk = 1'b1;
    #40 link_clk = 1'b0;
  endtask
  task automatic code(input logic f, input logic h);
    put(8'hFF);
    put(8'h00);
    put(8'h00);
    put({1'b1, f, 1'b0, h, h, f ^ h, f, f ^ h});
  endtask
  // Skip drops the start code; clock idles after the line
  task automatic line(input logic skip, input int n, input logic f);
    #3;
    if (!skip)
      code(f, 1'b0);
    for (int i = 0; i < n; i++)
      put(i[0] ? 8'h10 : 8'h80);
    code(f, 1'b1);
    link_data = ~link_data;
  endtask
endmodule
`default_nettype wire

//--- tb_video_capture_scaler.sv
// Testbench: registers, stream, reduction and errors
`default_nettype none
module tb_video_capture_scaler
  import vcap_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat, q;
  logic ack, irq, pv, capture_clock;
  logic [15:0] pd, last_pd;
  logic [7:0] vdata;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int pix_cnt = 0;
  always #5 clk_sys = ~clk_sys;
  video_capture_scaler i_video_capture_scaler (
    .CLK_SYS(clk_sys), .RST(rst), .WB_ADR_I(adr), .WB_DAT_I(dat),
    .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ(irq), .CAPTURE_CLOCK(capture_clock),
    .VIDEO_DATA(vdata), .PIX_VALID(pv), .PIX_DATA(pd), .PIX_X(),
    .PIX_LINE(), .DISP_FRAME(), .DISP_INTERLACE()
  );
  vcap_video_src i_vcap_video_src (.link_clk(capture_clock), .link_data(vdata));
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (pv === 1'b1) begin
      pix_cnt++;
      last_pd = pd;
    end
    if (cycles == 80000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d);
    @(posedge clk_sys);
    adr <= a;
    we <= w;
    dat <= d;
    cyc <= 1'b1;
    do
      @(posedge clk_sys);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic t_regs();
    rd("scale_rst", ADDR_SCALE, SCALE_RESET);
    wb(ADDR_SCALE, 1'b1, 32'h0968_08E3);
    rd("scale", ADDR_SCALE, 32'h0968_08E3);
    rd("unmapped", 8'h20, 32'h0);
    wb(ADDR_SCALE, 1'b1, 32'h0800_1000);
    wb(ADDR_LAYER, 1'b1, 32'h0000_0002);
  endtask
  task automatic t_line(input logic [31:0] mode, input int exp);
    wb(ADDR_MODE, 1'b1, mode);
    pix_cnt = 0;
    i_vcap_video_src.line(1'b0, LINE_WORDS, 1'b0);
    repeat (200) @(posedge clk_sys);
    chk("pixels", exp, 32'(pix_cnt));
    chk("pix_data", 32'h0000_1080, {16'h0, last_pd});
    rd("status", ADDR_STATUS, 32'h0);
  endtask
  task automatic t_err(input logic skip, input int n);
    wb(ADDR_MODE, 1'b1, 32'h0000_001F);
    wb(ADDR_IRQ_MASK, 1'b1, 32'h0000_0002);
    i_vcap_video_src.line(skip, n, 1'b1);
    repeat (200) @(posedge clk_sys);
    wb(ADDR_STATUS, 1'b0, 32'h0);
    chk("status_err", 32'h1, 32'(q[4:0] != 5'h00));
    chk("irq_on", 32'h1, 32'(irq));
    wb(ADDR_IRQ_MASK, 1'b1, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk("irq_masked", 32'h0, 32'(irq));
    wb(ADDR_STATUS, 1'b1, 32'h0000_001F);
    wb(ADDR_IRQ_STAT, 1'b1, 32'h0000_0003);
    wb(ADDR_IRQ_MASK, 1'b1, 32'h0000_0002);
    repeat (2) @(posedge clk_sys);
    chk("irq_clear", 32'h0, 32'(irq));
    rd("status_clr", ADDR_STATUS, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (130) @(posedge clk_sys);
    t_regs();
    t_line(32'h0000_0003, LINE_WORDS / 2);
    t_line(32'h0000_000F, LINE_WORDS / 4);
    t_line(32'h0000_0001, LINE_WORDS);
    t_err(1'b1, LINE_WORDS);
    t_err(1'b0, 100);
    end_of_test();
  end
endmodule
`default_nettype wire
